/* verilog/fbi_cfg.svh */
// Constants for the flash burst bus interface
`ifndef FBI_CFG_SVH
`define FBI_CFG_SVH
`define FBI_ADDR_W 19
`define FBI_DATA_W 16
`define FBI_CNT_W 5
`define FBI_CNT_FIRST 5'h00
`define FBI_CNT_LAST 5'h1F
`define FBI_SYNC_RESET 2'h3
`endif

/* verilog/fbi_pkg.sv */
// Types for the flash burst bus interface
package fbi_pkg;
	// Synchronised strobe levels, all active low
	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} fbi_strobes_t;
	// Decoded bus operation
	typedef enum logic [3:0] {
		FBI_OP_IDLE = 4'h1,
		FBI_OP_READ = 4'h2,
		FBI_OP_WRITE = 4'h4,
		FBI_OP_OFF = 4'h8
	} fbi_op_t;
	// Captured command cycle
	typedef struct packed {
		logic [18:0] addr;
		logic [15:0] data;
	} fbi_cmd_t;
endpackage : fbi_pkg

/* verilog/fbi_burst_if.sv */
// Host-facing bus interface with burst read path of a parallel flash
`timescale 1ns/100ps
`include "fbi_cfg.svh"
// Functional notes
// - Load strobe low in burst mode captures address
// - Load strobe high: address ignored, no load
// - Advance strobe low steps to next word
// - Advance strobe high holds word and position
// - End flag low only at start plus 31
// - After last word, advance wraps to start
// - Select and strobes are synchronised internally
// - Nineteen address bits, sixteen data bits
// - Commands held in unmapped internal latches
// - Advance with output gate high: outputs float
// - Advance with output gate low: drive word
// - Select high ends burst, outputs float
// - Load during burst restarts from new address
// - Suspend floats outputs, keeps word internally
// - Resume with gate only: same word
// - Resume with gate and advance: next word
// - Asynchronous mode ignores load, advance; reads still pass the clocked synchronisers and output flops
// - Counter clears on load, ends at 11111b
module fbi_burst_if
	import fbi_pkg::*;
#(
	parameter int ADDR_W = `FBI_ADDR_W,
	parameter int DATA_W = `FBI_DATA_W
)
(
	// Clock and synchronous reset
	input wire logic CLOCK,
	input wire logic RESET,
	// Mode from the command state machine
	input wire logic BURST_MODE,
	// Host strobes, all active low
	input wire logic CHIP_SEL_N,
	input wire logic OUT_GATE_N,
	input wire logic WRITE_STB_N,
	input wire logic BURST_START_LOAD_N,
	input wire logic BURST_STEP_N,
	// Host address and data bus
	// fixed bus widths
	input wire logic [ADDR_W-1:0] WORD_ADDRESS_BUS,
	input wire logic [DATA_W-1:0] DATA_BUS_WDATA,
	output logic [DATA_W-1:0] DATA_BUS_RDATA,
	output logic DATA_BUS_OE,
	// Array access
	output logic [ADDR_W-1:0] ARRAY_ADDR,
	input wire logic [DATA_W-1:0] ARRAY_DATA,
	// Command latch towards the state machine
	output logic [ADDR_W-1:0] CMD_ADDR,
	output logic [DATA_W-1:0] CMD_DATA,
	output logic CMD_VALID,
	// Burst status
	output logic BURST_LAST_WORD_N,
	output logic BURST_ACTIVE
);

	// Widths are tied to the pinout and the counter slice; other sizes are refused
	if (ADDR_W != `FBI_ADDR_W || DATA_W != `FBI_DATA_W)
	begin : g_width_check
		$error("fbi_burst_if: bus widths are fixed at 19 and 16");
	end

	// Two-stage synchronisers for the asynchronous pins
	fbi_strobes_t sync1_r;
	fbi_strobes_t sync2_r;
	logic [1:0] ls_s1_r;
	logic [1:0] ls_s2_r;
	logic [ADDR_W-1:0] addr_s1_r;
	logic [ADDR_W-1:0] addr_s2_r;
	logic [DATA_W-1:0] din_s1_r;
	logic [DATA_W-1:0] din_s2_r;
	// Burst state
	logic [ADDR_W-1:0] base_r;
	logic [`FBI_CNT_W-1:0] cnt_r;
	logic [`FBI_CNT_W-1:0] cnt_nxt;
	logic active_r;
	logic active_nxt;
	logic we_prev_r;
	fbi_cmd_t cmd_r;
	logic cmd_valid_r;
	logic [DATA_W-1:0] dout_r;
	logic oe_r;
	logic last_n_r;
	fbi_op_t op;

	// Decode of synchronised strobes, shared by several paths
	function automatic fbi_op_t decode_op(input fbi_strobes_t s);
		if (s.ce_n)
			return FBI_OP_OFF;
		else if (!s.oe_n && s.we_n)
			return FBI_OP_READ;
		else if (s.oe_n && !s.we_n)
			return FBI_OP_WRITE;
		else
			return FBI_OP_IDLE;
	endfunction : decode_op

	// two flop sync
	// Address and data take the same two stages, so they stay in step with the strobes
	always_ff @(posedge CLOCK)
	begin
		sync1_r <= '{ce_n: CHIP_SEL_N, oe_n: OUT_GATE_N, we_n: WRITE_STB_N};
		sync2_r <= sync1_r;
		ls_s1_r <= {BURST_START_LOAD_N, BURST_STEP_N};
		ls_s2_r <= ls_s1_r;
		addr_s1_r <= WORD_ADDRESS_BUS;
		addr_s2_r <= addr_s1_r;
		din_s1_r <= DATA_BUS_WDATA;
		din_s2_r <= din_s1_r;
	end

	// Named conditions on the synchronised inputs
	wire logic load_n = ls_s2_r[1];
	wire logic step_n = ls_s2_r[0];
	assign op = decode_op(sync2_r);
	wire logic sel = !sync2_r.ce_n;
	wire logic do_load = BURST_MODE && sel && sync2_r.we_n && !load_n && step_n;
	wire logic do_step = BURST_MODE && active_r && sel && sync2_r.we_n && load_n && !step_n;
	wire logic [`FBI_CNT_W-1:0] cnt_inc = cnt_r + `FBI_CNT_W'(1);
	// Next burst state; load wins over step since they are exclusive anyway
	always_comb
	begin
		cnt_nxt = cnt_r;
		active_nxt = active_r;
		if (!BURST_MODE || !sel)
		begin
			active_nxt = 1'b0;
		end
		else if (do_load)
		begin
			cnt_nxt = `FBI_CNT_FIRST;
			active_nxt = 1'b1;
		end
		else if (do_step)
			cnt_nxt = cnt_inc;
	end

	// Burst position registers; hold when no step or load
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			cnt_r <= `FBI_CNT_FIRST;
			active_r <= 1'b0;
			base_r <= '0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			active_r <= active_nxt;
			if (do_load)
				base_r <= addr_s2_r;
		end
	end

	// command latch, loaded on every write cycle; valid pulses after write strobe release
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			cmd_r <= '0;
			cmd_valid_r <= 1'b0;
			we_prev_r <= 1'b0;
		end
		else
		begin
			we_prev_r <= (op == FBI_OP_WRITE);
			cmd_valid_r <= we_prev_r && (op != FBI_OP_WRITE);
			if (op == FBI_OP_WRITE)
				cmd_r <= '{addr: addr_s2_r, data: din_s2_r};
		end
	end

	// Output word: burst word when active, else asynchronous array read
	wire logic [ADDR_W-1:0] rd_addr = active_nxt ?
		{(do_load ? addr_s2_r[ADDR_W-1:`FBI_CNT_W] : base_r[ADDR_W-1:`FBI_CNT_W]),
		((do_load ? addr_s2_r[`FBI_CNT_W-1:0] : base_r[`FBI_CNT_W-1:0]) + cnt_nxt)}
		: addr_s2_r;
	wire logic oe_nxt = (op == FBI_OP_READ) && !RESET;
	// last word flag, taken from the registered count so that it
	// rises and falls with the word on the bus, one cycle behind the address
	wire logic last_nxt_n = !(active_r && cnt_r == `FBI_CNT_LAST);

	// Output flops; the array is assumed combinational on ARRAY_ADDR
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			dout_r <= '0;
			oe_r <= 1'b0;
			last_n_r <= 1'b1;
			ARRAY_ADDR <= '0;
		end
		else
		begin
			ARRAY_ADDR <= rd_addr;
			oe_r <= oe_nxt;
			last_n_r <= last_nxt_n;
			// word kept while suspended: the address holds, so
			// the word holds; capturing every cycle keeps data one cycle behind it
			dout_r <= ARRAY_DATA;
		end
	end

	// Outputs straight from flops
	assign DATA_BUS_RDATA = dout_r;
	assign DATA_BUS_OE = oe_r;
	assign BURST_LAST_WORD_N = last_n_r;
	assign BURST_ACTIVE = active_r;
	assign CMD_ADDR = cmd_r.addr;
	assign CMD_DATA = cmd_r.data;
	assign CMD_VALID = cmd_valid_r;

	// Assertions
	property p_load;
		@(posedge CLOCK) disable iff (RESET) do_load |=> cnt_r == 5'h00 && active_r;
	endproperty
	a_load: assert property (p_load) else $error("load did not clear counter");
	property p_noload;
		@(posedge CLOCK) disable iff (RESET) (load_n && active_r) |=> $stable(base_r);
	endproperty
	a_noload: assert property (p_noload) else $error("base changed without load");
	property p_step;
		@(posedge CLOCK) disable iff (RESET) do_step |=> cnt_r == $past(cnt_r) + 5'h01;
	endproperty
	a_step: assert property (p_step) else $error("advance did not step");
	property p_hold;
		@(posedge CLOCK) disable iff (RESET)
		(active_r && sel && BURST_MODE && step_n && load_n) |=> $stable(cnt_r);
	endproperty
	a_hold: assert property (p_hold) else $error("position moved without advance");
	property p_last;
		@(posedge CLOCK) disable iff (RESET)
		!last_n_r |-> $past(active_r) && $past(cnt_r) == 5'h1F;
	endproperty
	a_last: assert property (p_last) else $error("end flag at wrong word");
	property p_wrap;
		@(posedge CLOCK) disable iff (RESET) (do_step && cnt_r == 5'h1F) |=> cnt_r == 5'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap after last word");
	property p_term;
		@(posedge CLOCK) disable iff (RESET) !sel |=> !active_r && !DATA_BUS_OE;
	endproperty
	a_term: assert property (p_term) else $error("select high did not end burst");
	property p_float;
		@(posedge CLOCK) disable iff (RESET) sync2_r.oe_n |=> !DATA_BUS_OE;
	endproperty
	a_float: assert property (p_float) else $error("drove bus with gate high");
	property p_async;
		@(posedge CLOCK) disable iff (RESET) !BURST_MODE |=> !active_r;
	endproperty
	a_async: assert property (p_async) else $error("burst active in async mode");
	property p_drive;
		@(posedge CLOCK) disable iff (RESET) (op == FBI_OP_READ) |=> DATA_BUS_OE;
	endproperty
	a_drive: assert property (p_drive) else $error("gate low did not drive bus");
	property p_quiet;
		@(posedge CLOCK) disable iff (RESET) (do_step && sync2_r.oe_n) |=> !DATA_BUS_OE;
	endproperty
	a_quiet: assert property (p_quiet) else $error("advance with gate high drove bus");
	property p_restart;
		@(posedge CLOCK) disable iff (RESET)
		(do_load && active_r) |=> base_r == $past(addr_s2_r) && cnt_r == 5'h00;
	endproperty
	a_restart: assert property (p_restart) else $error("reload did not restart");
	property p_same;
		@(posedge CLOCK) disable iff (RESET)
		(active_r && active_nxt && !do_step && !do_load) |=> $stable(ARRAY_ADDR);
	endproperty
	a_same: assert property (p_same) else $error("held word moved");
	property p_next;
		@(posedge CLOCK) disable iff (RESET)
		do_step |=> ARRAY_ADDR[4:0] == $past(ARRAY_ADDR[4:0]) + 5'h01;
	endproperty
	a_next: assert property (p_next) else $error("advance skipped a word");
	property p_last_set;
		@(posedge CLOCK) disable iff (RESET) (active_r && cnt_r == 5'h1F) |=> !last_n_r;
	endproperty
	a_last_set: assert property (p_last_set) else $error("end flag missing");
	property p_cmd;
		@(posedge CLOCK) disable iff (RESET)
		(op == FBI_OP_WRITE) |=> CMD_ADDR == $past(addr_s2_r) && CMD_DATA == $past(din_s2_r);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command latch missed write");
	// Main scenarios worth seeing in a run
	c_load: cover property (@(posedge CLOCK) disable iff (RESET) do_load);
	c_wrap: cover property (@(posedge CLOCK) disable iff (RESET) do_step && cnt_r == 5'h1F);
	c_susp: cover property (@(posedge CLOCK) disable iff (RESET)
		active_r && sync2_r.oe_n && step_n ##1 do_step);
	c_restart: cover property (@(posedge CLOCK) disable iff (RESET) do_load && active_r);
	c_desel: cover property (@(posedge CLOCK) disable iff (RESET) active_r && !sel);
endmodule : fbi_burst_if

/* dv/fbi_array_model.sv */
// Array stand-in that answers each word address with a fixed pattern
`timescale 1ns/100ps
module fbi_array_model
	import fbi_pkg::*;
(
	// Array side of the interface
	input wire logic [18:0] ADDR,
	output logic [15:0] DATA
);
	// Pattern folds bits 18:16 onto bits 15:13, so addresses that differ alike in both fields give the same word
	assign DATA = ADDR[15:0] ^ 16'h5A3C ^ {ADDR[18:16], 13'h0000};
endmodule : fbi_array_model

/* dv/fbi_burst_if_tb.sv */
// Self-checking bench for the flash burst bus interface
`timescale 1ns/100ps
module fbi_burst_if_tb
	import fbi_pkg::*;
;
	// Pin sets {select, gate, write, load, step}, all active low
	localparam logic [4:0] HOLD = 5'h07, LOAD = 5'h05, STEP = 5'h06, SUSP = 5'h0F;
	localparam logic [4:0] GSTEP = 5'h0E, WR = 5'h0B, DESEL = 5'h17;
	logic CLOCK = 1'b0, RESET = 1'b1, mode = 1'b0, cval, oe, last_n, act;
	logic ce_n = 1'b1, oe_n = 1'b1, we_n = 1'b1, ld_n = 1'b1, st_n = 1'b1;
	logic [18:0] addr = 19'h00000, base = 19'h00000, aaddr, caddr;
	logic [15:0] din = 16'h0000, dout, adata, cdata;
	int err_total = 0, compares = 0;
	always #25 CLOCK = ~CLOCK;
	fbi_burst_if i_fbi_burst_if (.CLOCK(CLOCK), .RESET(RESET), .BURST_MODE(mode),
		.CHIP_SEL_N(ce_n), .OUT_GATE_N(oe_n), .WRITE_STB_N(we_n),
		.BURST_START_LOAD_N(ld_n), .BURST_STEP_N(st_n), .WORD_ADDRESS_BUS(addr),
		.DATA_BUS_WDATA(din), .DATA_BUS_RDATA(dout), .DATA_BUS_OE(oe), .ARRAY_ADDR(aaddr),
		.ARRAY_DATA(adata), .CMD_ADDR(caddr), .CMD_DATA(cdata), .CMD_VALID(cval),
		.BURST_LAST_WORD_N(last_n), .BURST_ACTIVE(act));
	fbi_array_model i_fbi_array_model (.ADDR(aaddr), .DATA(adata));
	// Bench copy of the array pattern
	function automatic logic [15:0] wexp(input logic [18:0] a);
		return a[15:0] ^ 16'h5A3C ^ {a[18:16], 13'h0000};
	endfunction : wexp
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Pins change at a falling edge and stand n cycles; sync delay hides under n
	task automatic pins(input logic [4:0] v, input int n);
		@(negedge CLOCK);
		{ce_n, oe_n, we_n, ld_n, st_n} = v;
		repeat (n - 1) @(negedge CLOCK);
	endtask : pins
	// Word at block offset lo, drive enable and end flag
	task automatic ck(input logic [4:0] lo, input logic en, input logic ln);
		chk(aaddr, {base[18:5], lo});
		chk(dout, wexp({base[18:5], lo}));
		chk(oe, en);
		chk(last_n, ln);
	endtask : ck
	task automatic t_async;
		addr = 19'h12348;
		pins(LOAD, 1);
		pins(STEP, 4);
		pins(HOLD, 7);
		chk(act, 1'b0);
		chk(aaddr, 19'h12348);
		chk(dout, wexp(19'h12348));
		chk(oe, 1'b1);
		$display("test async done");
	endtask : t_async
	task automatic t_load;
		mode = 1'b1;
		base = addr;
		pins(LOAD, 1);
		// Address stands with the strobe, then leaves so a stray load would show
		pins(HOLD, 1);
		addr = 19'h00000;
		pins(HOLD, 6);
		chk(act, 1'b1);
		ck(5'h08, 1'b1, 1'b1);
		$display("test load done");
	endtask : t_load
	task automatic t_wrap;
		pins(STEP, 31);
		pins(HOLD, 7);
		ck(5'h07, 1'b1, 1'b0);
		pins(STEP, 1);
		pins(HOLD, 7);
		ck(5'h08, 1'b1, 1'b1);
		$display("test wrap done");
	endtask : t_wrap
	task automatic t_susp;
		pins(SUSP, 7);
		ck(5'h08, 1'b0, 1'b1);
		pins(HOLD, 7);
		ck(5'h08, 1'b1, 1'b1);
		pins(GSTEP, 3);
		pins(SUSP, 7);
		ck(5'h0B, 1'b0, 1'b1);
		pins(STEP, 1);
		pins(HOLD, 7);
		ck(5'h0C, 1'b1, 1'b1);
		$display("test suspend done");
	endtask : t_susp
	task automatic t_restart;
		addr = 19'h7FFF5;
		base = addr;
		pins(LOAD, 1);
		pins(HOLD, 7);
		ck(5'h15, 1'b1, 1'b1);
		pins(STEP, 10);
		pins(HOLD, 7);
		ck(5'h1F, 1'b1, 1'b1);
		pins(DESEL, 7);
		chk(oe, 1'b0);
		chk(act, 1'b0);
		$display("test restart done");
	endtask : t_restart
	task automatic t_write;
		int n;
		n = 0;
		addr = 19'h2AAAA;
		din = 16'h55AA;
		pins(WR, 4);
		pins(SUSP, 1);
		// Bounded watch for the capture pulse
		repeat (12)
		begin
			@(negedge CLOCK);
			if (cval === 1'b1)
				n++;
		end
		chk(n, 1);
		chk(caddr, 19'h2AAAA);
		chk(cdata, 16'h55AA);
		$display("test write done");
	endtask : t_write
	task automatic results;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// Reset long enough to flush the input synchronisers
	initial
	begin
		repeat (16) @(negedge CLOCK);
		RESET = 1'b0;
		repeat (3) @(negedge CLOCK);
		t_async();
		t_load();
		t_wrap();
		t_susp();
		t_restart();
		t_write();
		results();
	end
endmodule : fbi_burst_if_tb
